/* File: jtdr_map.svh */
// Constants for the test data register block: opcodes, ID layout, resets, timing
`ifndef JTDR_MAP_SVH
`define JTDR_MAP_SVH

// Instruction opcodes
`define JTDR_IR_W              4
`define JTDR_OP_EXTEST         4'h0
`define JTDR_OP_IDENTIFY       4'h1
`define JTDR_OP_SAMPLE         4'h2
`define JTDR_OP_RESET_HOLD     4'hc
`define JTDR_OP_BYPASS         4'hf

// Identification word layout
`define JTDR_ID_W              32
`define JTDR_ID_VER_MSB        31
`define JTDR_ID_VER_LSB        28
`define JTDR_ID_PART_MSB       27
`define JTDR_ID_PART_LSB       12
`define JTDR_ID_MFR_MSB        11
`define JTDR_ID_MFR_LSB        1
`define JTDR_ID_FIXED_BIT      0
// Arbitrary identity values
`define JTDR_ID_VER_BASE       4'h1
`define JTDR_ID_PART           16'h5a3c
`define JTDR_ID_MFR            11'h2b5

// Reset values
`define JTDR_BYP_RST           1'b0
`define JTDR_RSTREG_RST        1'b0
`define JTDR_TDO_RST           1'b0

// Timing
`define JTDR_CORE_CLK_MHZ      200
`define JTDR_TOUT_MID_US       4100
`define JTDR_TOUT_LONG_US      65000
`define JTDR_TOUT_NONE_CYC     32'h0000_0001
`define JTDR_FUSE_W            2
`define JTDR_FUSE_NONE         2'h0
`define JTDR_FUSE_MID          2'h1

`endif

/* File: jtdr_pkg.sv */
// Types shared by the test data register block
package jtdr_pkg;
  typedef enum logic [1:0] {
    JTDR_SEL_ID,
    JTDR_SEL_BYP,
    JTDR_SEL_RST,
    JTDR_SEL_BSC
  } jtdr_dr_sel_t;

  typedef enum logic [1:0] {
    JTDR_ST_RUN,
    JTDR_ST_HOLD,
    JTDR_ST_TOUT
  } jtdr_rst_st_t;
endpackage

/* File: jtdr_sync.sv */
// Two-flop level synchroniser into the core clock domain
module jtdr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Level in and out
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

/* File: jtdr_top.sv */
// Bypass, identification and reset-hold test data registers with device reset logic
`include "jtdr_map.svh"

module jtdr_top #(
  parameter logic [3:0]  REV_INDEX     = 4'h0,
  parameter logic [31:0] TOUT_MID_CYC  = `JTDR_TOUT_MID_US * `JTDR_CORE_CLK_MHZ,
  parameter logic [31:0] TOUT_LONG_CYC = `JTDR_TOUT_LONG_US * `JTDR_CORE_CLK_MHZ
) (
  // Core clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // Link clock and TAP state controls
  input  wire logic                      tck_i,
  input  wire logic                      test_logic_reset_i,
  input  wire logic                      capture_dr_i,
  input  wire logic                      shift_dr_i,
  input  wire logic                      update_dr_i,
  input  wire logic                      update_ir_i,
  input  wire logic [`JTDR_IR_W-1:0]     ir_value_i,
  // Serial data
  input  wire logic                      tdi_i,
  input  wire logic                      bsc_tdo_i,
  output logic                           tdo_o,
  output logic                           tdo_oe_n_o,
  // Device reset
  input  wire logic                      external_reset_pin_n_i,
  input  wire logic [`JTDR_FUSE_W-1:0]   fuse_clk_opt_i,
  output logic                           device_reset_o,
  output logic [`JTDR_IR_W-1:0]          instr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic jtdr_pkg::jtdr_dr_sel_t sel_of(input logic [`JTDR_IR_W-1:0] op);
    jtdr_pkg::jtdr_dr_sel_t s;
    s = jtdr_pkg::JTDR_SEL_BYP;
    if (op == `JTDR_OP_IDENTIFY) begin
      s = jtdr_pkg::JTDR_SEL_ID;
    end else if (op == `JTDR_OP_RESET_HOLD) begin
      s = jtdr_pkg::JTDR_SEL_RST;
    end else if (op == `JTDR_OP_EXTEST || op == `JTDR_OP_SAMPLE) begin
      s = jtdr_pkg::JTDR_SEL_BSC;
    end
    return s;
  endfunction

  function automatic logic [31:0] tout_cycles(input logic [`JTDR_FUSE_W-1:0] f);
    logic [31:0] c;
    c = TOUT_LONG_CYC;
    if (f == `JTDR_FUSE_NONE) begin
      c = `JTDR_TOUT_NONE_CYC;
    end else if (f == `JTDR_FUSE_MID) begin
      c = TOUT_MID_CYC;
    end
    return (c == 32'h0) ? `JTDR_TOUT_NONE_CYC : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain

  logic [`JTDR_IR_W-1:0]  instr_q;
  logic                   byp_q;
  logic [`JTDR_ID_W-1:0]  id_sr_q;
  logic                   rst_reg_q;
  logic                   tdo_q;
  logic                   tdo_oe_n_q;

  jtdr_pkg::jtdr_dr_sel_t dr_sel;
  wire                    sel_id  = (dr_sel == jtdr_pkg::JTDR_SEL_ID);
  wire                    sel_byp = (dr_sel == jtdr_pkg::JTDR_SEL_BYP);
  wire                    sel_rst = (dr_sel == jtdr_pkg::JTDR_SEL_RST);
  wire [3:0]              id_ver  = `JTDR_ID_VER_BASE + REV_INDEX;
  wire [`JTDR_ID_W-1:0]   id_word = {id_ver, `JTDR_ID_PART, `JTDR_ID_MFR, 1'b1};
  logic                   tdo_d;

  assign dr_sel = sel_of(instr_q);

  // Active instruction; identify after test-logic reset
  always_ff @(posedge tck_i) begin
    if (test_logic_reset_i) begin
      instr_q <= `JTDR_OP_IDENTIFY;
    end else if (update_ir_i) begin
      instr_q <= ir_value_i;
    end
  end

  // Single bypass stage
  always_ff @(posedge tck_i) begin
    if (test_logic_reset_i) begin
      byp_q <= `JTDR_BYP_RST;
    end else if (sel_byp && capture_dr_i) begin
      byp_q <= 1'b0;
    end else if (sel_byp && shift_dr_i) begin
      byp_q <= tdi_i;
    end
  end

  // Identification shift path, LSB out first
  always_ff @(posedge tck_i) begin
    if (test_logic_reset_i) begin
      id_sr_q <= id_word;
    end else if (sel_id && capture_dr_i) begin
      id_sr_q <= id_word;
    end else if (sel_id && shift_dr_i) begin
      id_sr_q <= {tdi_i, id_sr_q[`JTDR_ID_W-1:1]};
    end
  end

  // Reset register: shift only, no capture, no update latch
  always_ff @(posedge tck_i) begin
    if (test_logic_reset_i) begin
      rst_reg_q <= `JTDR_RSTREG_RST;
    end else if (sel_rst && shift_dr_i) begin
      rst_reg_q <= tdi_i;
    end
  end

  always_comb begin
    unique case (dr_sel)
      jtdr_pkg::JTDR_SEL_ID:  tdo_d = id_sr_q[0];
      jtdr_pkg::JTDR_SEL_BYP: tdo_d = byp_q;
      jtdr_pkg::JTDR_SEL_RST: tdo_d = rst_reg_q;
      jtdr_pkg::JTDR_SEL_BSC: tdo_d = bsc_tdo_i;
    endcase
  end

  // Serial output changes on the falling edge, driven only while shifting
  always_ff @(negedge tck_i) begin
    if (test_logic_reset_i) begin
      tdo_q      <= `JTDR_TDO_RST;
      tdo_oe_n_q <= 1'b1;
    end else begin
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= ~shift_dr_i;
    end
  end

  assign tdo_o      = tdo_q;
  assign tdo_oe_n_o = tdo_oe_n_q;
  assign instr_o    = instr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain

  logic                     pin_n_s;
  logic                     jrst_s;
  logic [`JTDR_FUSE_W-1:0]  fuse_s;
  jtdr_pkg::jtdr_rst_st_t   st_q;
  jtdr_pkg::jtdr_rst_st_t   st_d;
  logic [31:0]              cnt_q;
  logic [31:0]              cnt_d;
  logic                     dev_rst_q;

  jtdr_sync #(.WIDTH(1)) u_pin_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (external_reset_pin_n_i),
    .q_o     (pin_n_s)
  );

  // Reset register level crosses unlatched, so reset asserts on it without an update; release still waits for the time-out
  jtdr_sync #(.WIDTH(1)) u_jrst_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (rst_reg_q),
    .q_o     (jrst_s)
  );

  // Fuses are static, a plain level crossing is enough
  jtdr_sync #(.WIDTH(`JTDR_FUSE_W)) u_fuse_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (fuse_clk_opt_i),
    .q_o     (fuse_s)
  );

  // Test port reset acts exactly like the pin
  wire src_rst = ~pin_n_s | jrst_s;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      jtdr_pkg::JTDR_ST_RUN: begin
        if (src_rst) begin
          st_d = jtdr_pkg::JTDR_ST_HOLD;
        end
      end
      jtdr_pkg::JTDR_ST_HOLD: begin
        if (!src_rst) begin
          st_d  = jtdr_pkg::JTDR_ST_TOUT;
          cnt_d = tout_cycles(fuse_s) - 32'h1;
        end
      end
      jtdr_pkg::JTDR_ST_TOUT: begin
        if (src_rst) begin
          st_d = jtdr_pkg::JTDR_ST_HOLD;
        end else if (cnt_q == 32'h0) begin
          st_d = jtdr_pkg::JTDR_ST_RUN;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      default: begin
        st_d = jtdr_pkg::JTDR_ST_HOLD;
      end
    endcase
  end

  // Held reset also floats the port pins, so no high-Z instruction exists
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q      <= jtdr_pkg::JTDR_ST_HOLD;
      cnt_q     <= 32'h0;
      dev_rst_q <= 1'b1;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      dev_rst_q <= (st_d != jtdr_pkg::JTDR_ST_RUN);
    end
  end

  assign device_reset_o = dev_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, link domain

  property p_byp_one_stage;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_byp && shift_dr_i && !update_ir_i) |=> (byp_q == $past(tdi_i));
  endproperty
  a_byp_one_stage: assert property (p_byp_one_stage) else $error("bypass not one stage");

  property p_byp_capture_zero;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_byp && capture_dr_i && !update_ir_i) |=> !byp_q;
  endproperty
  a_byp_capture_zero: assert property (p_byp_capture_zero) else $error("bypass not cleared");

  property p_id_fields;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_id && capture_dr_i) |=> id_sr_q[`JTDR_ID_FIXED_BIT] &&
        (id_sr_q[`JTDR_ID_MFR_MSB:`JTDR_ID_MFR_LSB] == `JTDR_ID_MFR);
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("id word fields wrong");

  property p_id_part;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_id && capture_dr_i) |=> (id_sr_q[`JTDR_ID_PART_MSB:`JTDR_ID_PART_LSB] == `JTDR_ID_PART);
  endproperty
  a_id_part: assert property (p_id_part) else $error("part number wrong");

  property p_id_version;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_id && capture_dr_i) |=>
        (id_sr_q[`JTDR_ID_VER_MSB:`JTDR_ID_VER_LSB] == 4'(`JTDR_ID_VER_BASE + REV_INDEX));
  endproperty
  a_id_version: assert property (p_id_version) else $error("version wrong");

  property p_rst_reg_shift;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_rst && shift_dr_i) |=> (rst_reg_q == $past(tdi_i));
  endproperty
  a_rst_reg_shift: assert property (p_rst_reg_shift) else $error("reset register not direct");

  property p_rst_reg_hold;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      !(sel_rst && shift_dr_i) |=> $stable(rst_reg_q);
  endproperty
  a_rst_reg_hold: assert property (p_rst_reg_hold) else $error("reset register moved");

  property p_no_update_action;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      update_dr_i |=> $stable(rst_reg_q) && $stable(byp_q);
  endproperty
  a_no_update_action: assert property (p_no_update_action) else $error("update step changed a register");

  property p_tlr_identify;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      $past(test_logic_reset_i) |-> (instr_q == `JTDR_OP_IDENTIFY) && !rst_reg_q;
  endproperty
  a_tlr_identify: assert property (p_tlr_identify) else $error("test reset state wrong");

  property p_id_lsb_first;
    @(posedge tck_i) disable iff (test_logic_reset_i)
      (sel_id && shift_dr_i && !capture_dr_i) |=>
        (id_sr_q[30:0] == $past(id_sr_q[31:1])) && (id_sr_q[31] == $past(tdi_i));
  endproperty
  a_id_lsb_first: assert property (p_id_lsb_first) else $error("id not lsb first");

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, core domain

  property p_src_holds_reset;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      src_rst |=> dev_rst_q ##1 dev_rst_q;
  endproperty
  a_src_holds_reset: assert property (p_src_holds_reset) else $error("reset not held");

  property p_tout_start;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_q == jtdr_pkg::JTDR_ST_HOLD && !src_rst) |=>
        (st_q == jtdr_pkg::JTDR_ST_TOUT) && dev_rst_q && (cnt_q == tout_cycles($past(fuse_s)) - 32'h1);
  endproperty
  a_tout_start: assert property (p_tout_start) else $error("time-out not started");

  property p_tout_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (st_q == jtdr_pkg::JTDR_ST_TOUT && cnt_q != 32'h0) |=> dev_rst_q;
  endproperty
  a_tout_hold: assert property (p_tout_hold) else $error("released before time-out");

  c_bypass_scan: cover property (@(posedge tck_i) sel_byp && capture_dr_i ##1 shift_dr_i [*2]);
  c_id_scan:     cover property (@(posedge tck_i) sel_id && capture_dr_i ##1 shift_dr_i [*8]);
  c_rst_set:     cover property (@(posedge tck_i) sel_rst && shift_dr_i && tdi_i);
  c_release:     cover property (@(posedge core_clk_i) $fell(dev_rst_q));

endmodule

/* File: jtdr_tester.sv */
// Tester model: drives link clock and TAP state controls, reads TDO
module jtdr_tester (
  // Link clock and state controls {tlr, capture, shift, update_dr, update_ir}
  output logic       tck_o,
  output logic [4:0] ctl_o,
  output logic [3:0] ir_o,
  output logic       tdi_o,
  // Serial return
  input  wire logic  tdo_i,
  input  wire logic  tdo_oe_n_i
);
  timeunit 1ns;
  timeprecision 1ps;

  logic tdo_seen;
  logic tdo_oe_n_seen;

  initial begin
    ctl_o = 5'h00;
    ir_o = 4'h1;
    tdi_o = 1'b1;
    tck_o = 1'b1;
    tdo_seen = 1'b0;
    tdo_oe_n_seen = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // One link period; clock idles high and stands still between frames
  // State changes after the rise, as a real TAP would, so the fall sees it
  task automatic cyc(input logic [4:0] c, input logic d);
    ctl_o = c;
    tdi_o = d;
    #40 tck_o = 1'b0;
    #80;
    // Released output reads as the inverse of its last value
    tdo_seen = tdo_oe_n_i ? ~tdo_i : tdo_i;
    tdo_oe_n_seen = tdo_oe_n_i;
    tck_o = 1'b1;
    #1 tdi_o = ~d;
    #39;
  endtask

  task automatic tap_reset();
    cyc(5'h10, 1'b0);
    cyc(5'h10, 1'b1);
  endtask

  task automatic load_ir(input logic [3:0] v);
    ir_o = v;
    cyc(5'h01, 1'b1);
  endtask

  // Capture, n shifts, update; LSB first both ways
  // Bit k is seen at shift k; index n holds what the update period shows
  task automatic scan(input int n, input logic [31:0] din, output logic [32:0] dout,
                      output logic [32:0] oe_n);
    dout = '0;
    oe_n = '0;
    cyc(5'h08, 1'b1);
    for (int k = 0; k < n; k++) begin
      cyc(5'h04, din[k % 32]);
      dout[k] = tdo_seen;
      oe_n[k] = tdo_oe_n_seen;
    end
    cyc(5'h02, 1'b1);
    if (n < 33) begin
      dout[n] = tdo_seen;
      oe_n[n] = tdo_oe_n_seen;
    end
  endtask
endmodule

/* File: jtdr_top_tb.sv */
// Self-checking bench for the test data registers and device reset path
`include "jtdr_map.svh"

module jtdr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [3:0] REV = 4'h2;
  localparam int MID = 20;
  localparam int LONG = 40;

  logic        core_clk_i, rst_n_i, pin_n, bsc_tdo, tdo, tdo_oe_n, dev_rst, tck, tdi;
  logic [4:0]  ctl;
  logic [3:0]  ir, instr;
  logic [1:0]  fuse;
  logic [32:0] dout, oe;
  logic [31:0] seed, din;
  logic [3:0]  v;
  int          n_errors, tests_run, cnt, len;

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  jtdr_top #(.REV_INDEX(REV), .TOUT_MID_CYC(32'(MID)), .TOUT_LONG_CYC(32'(LONG))) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .test_logic_reset_i(ctl[4]),
    .capture_dr_i(ctl[3]), .shift_dr_i(ctl[2]), .update_dr_i(ctl[1]), .update_ir_i(ctl[0]),
    .ir_value_i(ir), .tdi_i(tdi), .bsc_tdo_i(bsc_tdo), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .external_reset_pin_n_i(pin_n), .fuse_clk_opt_i(fuse), .device_reset_o(dev_rst),
    .instr_o(instr));

  jtdr_tester tester (.tck_o(tck), .ctl_o(ctl), .ir_o(ir), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_n_i(tdo_oe_n));

  ////////////////////////////////////////////////////////////
  function automatic logic [32:0] id_word(input logic first_in);
    return {first_in, `JTDR_ID_VER_BASE + REV, `JTDR_ID_PART, `JTDR_ID_MFR, 1'b1};
  endfunction

  function automatic int tout(input logic [1:0] f);
    return (f == 2'h0) ? 1 : (f == 2'h1) ? MID : LONG;
  endfunction

  task automatic check_vec(input logic [32:0] got, input logic [32:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi, input string what);
    tests_run++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for device reset release, in core cycles
  task automatic to_release(output int c);
    c = 0;
    while (dev_rst !== 1'b0) begin
      @(posedge core_clk_i);
      #1;
      c++;
      if (c > 1000) begin
        check_cnt(c, 0, 1000, "release wait");
        test_done();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h9c3418a4;
    n_errors = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    pin_n = 1'b1;
    fuse = 2'h0;
    bsc_tdo = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1 check_vec({32'h0, dev_rst}, 33'h1, "reset during core reset");
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    tester.tap_reset();
    check_vec({29'h0, instr}, {29'h0, `JTDR_OP_IDENTIFY}, "instr after tlr");
    to_release(cnt);
    $display("Test power-up done");
    // First scan without loading an instruction returns the ID word
    din = $random(seed);
    // 33rd bit out is the first bit shifted in
    tester.scan(33, din, dout, oe);
    check_vec(dout, id_word(din[0]), "id word");
    check_vec(oe, 33'h0, "tdo enable");
    $display("Test identify done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 4'hf : (i == 1) ? 4'h8 : 4'($random(seed));
      if (v == 4'h0 || v == 4'h1 || v == 4'h2 || v == 4'hc) v = `JTDR_OP_BYPASS;
      // Last bit one, so the next capture must clear it
      din = $random(seed) | 32'h80;
      tester.load_ir(v);
      check_vec({29'h0, instr}, {29'h0, v}, "instr load");
      tester.scan(8, din, dout, oe);
      check_vec({25'h0, dout[7:0]}, {25'h0, din[6:0], 1'b0}, "bypass path");
      check_vec({24'h0, oe[8:0]}, 33'h100, "bypass enable");
    end
    $display("Test bypass done");
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? `JTDR_OP_EXTEST : `JTDR_OP_SAMPLE;
      @(posedge core_clk_i);
      bsc_tdo <= v[1];
      tester.load_ir(v);
      tester.scan(4, 32'h5, dout, oe);
      check_vec({29'h0, dout[3:0]}, {29'h0, {4{v[1]}}}, "boundary path");
    end
    $display("Test boundary done");
    // Reset hold used in place of a high-Z instruction
    @(posedge core_clk_i);
    fuse <= 2'h2;
    tester.load_ir(`JTDR_OP_RESET_HOLD);
    tester.cyc(5'h08, 1'b0);
    tester.cyc(5'h04, 1'b1);
    repeat (8) @(posedge core_clk_i);
    #1 check_vec({32'h0, dev_rst}, 33'h1, "reset without update");
    repeat (100) @(posedge core_clk_i);
    #1 check_vec({32'h0, dev_rst}, 33'h1, "reset held");
    tester.cyc(5'h08, 1'b1);
    tester.cyc(5'h04, 1'b0);
    check_vec({32'h0, tester.tdo_seen}, 33'h1, "capture keeps reset bit");
    // Eight core cycles pass between the clearing edge and the wait
    to_release(cnt);
    check_cnt(cnt + 8, LONG + 2, LONG + 6, "timeout after register");
    tester.cyc(5'h02, 1'b1);
    @(posedge core_clk_i);
    fuse <= 2'h0;
    tester.cyc(5'h08, 1'b0);
    tester.cyc(5'h04, 1'b1);
    tester.tap_reset();
    tester.cyc(5'h00, 1'b0);
    to_release(cnt);
    check_cnt(cnt, 0, 0, "tlr clears reset register");
    $display("Test reset register done");
    for (int f = 0; f < 4; f++) begin
      len = 5 + int'(seed[2:0]);
      din = $random(seed);
      @(posedge core_clk_i);
      fuse <= 2'(f);
      repeat (4) @(posedge core_clk_i);
      pin_n <= 1'b0;
      repeat (len) @(posedge core_clk_i);
      #1 check_vec({32'h0, dev_rst}, 33'h1, "pin reset");
      @(posedge core_clk_i);
      pin_n <= 1'b1;
      to_release(cnt);
      check_cnt(cnt, tout(2'(f)) + 1, tout(2'(f)) + 5, "pin timeout");
    end
    $display("Test pin reset done");
    test_done();
  end
endmodule
